/* src/mpfc_defines.svh */
// constants for the pause and fault control block
`ifndef MPFC_DEFINES_SVH
`define MPFC_DEFINES_SVH
`define MPFC_ADDR_ZERO 48'h000000000000
`define MPFC_PAUSE_GROUP_ADDR 48'h0180C2000001
`define MPFC_CTRL_ETHERTYPE 16'h8808
`define MPFC_GLOBAL_OPCODE_MIN 16'h0000
`define MPFC_GLOBAL_OPCODE_MAX 16'hFFFF
`define MPFC_PRIO_OPCODE_MIN 16'h0000
`define MPFC_PRIO_OPCODE_MAX 16'h0FFF
`define MPFC_GLOBAL_PAUSE_OPCODE 16'h0001
`define MPFC_PRIO_PAUSE_OPCODE 16'h0101
`define MPFC_ACK_W 9
`define MPFC_DA_HI 47
`define MPFC_SA_HI 95
`define MPFC_SA_LO 48
`define MPFC_ET_HI 111
`define MPFC_ET_LO 96
`define MPFC_OP_HI 127
`define MPFC_OP_LO 112
`define MPFC_HDR_W 128
`endif

/* src/mpfc_pkg.sv */
// types shared by the pause and fault control block
package mpfc_pkg;
  typedef enum logic [1:0] {
    MPFC_CLS_DATA,
    MPFC_CLS_CTRL,
    MPFC_CLS_GPAUSE,
    MPFC_CLS_PPAUSE
  } mpfc_class_t;
endpackage : mpfc_pkg

/* src/mpfc_classify.sv */
// header classifier: decides whether a frame is data, control or pause
`timescale 1ns/1ns
`include "mpfc_defines.svh"
module mpfc_classify (
  input wire logic [`MPFC_HDR_W-1:0] i_hdr,
  input wire logic [47:0] i_rx_pause_unicast_dest_addr,
  input wire logic [47:0] i_rx_pause_multicast_dest_addr,
  input wire logic [15:0] i_rx_global_ctrl_ethertype,
  input wire logic [15:0] i_rx_global_ctrl_opcode_min,
  input wire logic [15:0] i_rx_global_ctrl_opcode_max,
  input wire logic [15:0] i_rx_priority_ctrl_ethertype,
  input wire logic [15:0] i_rx_priority_ctrl_opcode_min,
  input wire logic [15:0] i_rx_priority_ctrl_opcode_max,
  input wire logic [15:0] i_rx_global_pause_ethertype,
  input wire logic [15:0] i_rx_global_pause_opcode,
  input wire logic [15:0] i_rx_priority_pause_ethertype,
  input wire logic [15:0] i_rx_priority_pause_opcode,
  output mpfc_pkg::mpfc_class_t o_class
);
  import mpfc_pkg::*;
  logic [47:0] da;
  logic [15:0] et;
  logic [15:0] op;
  logic da_ok;
  assign da = i_hdr[`MPFC_DA_HI:0];
  assign et = i_hdr[`MPFC_ET_HI:`MPFC_ET_LO];
  assign op = i_hdr[`MPFC_OP_HI:`MPFC_OP_LO];
  assign da_ok = (da == i_rx_pause_unicast_dest_addr) || (da == i_rx_pause_multicast_dest_addr);
  // destination, ethertype and opcode must match, source not compared; pause beats generic control
  always_comb begin
    o_class = MPFC_CLS_DATA;
    if (da_ok) begin
      if (et == i_rx_global_pause_ethertype && op == i_rx_global_pause_opcode) begin
        o_class = MPFC_CLS_GPAUSE;
      end else if (et == i_rx_priority_pause_ethertype && op == i_rx_priority_pause_opcode) begin
        o_class = MPFC_CLS_PPAUSE;
      end else if (et == i_rx_global_ctrl_ethertype && op >= i_rx_global_ctrl_opcode_min &&
                   op <= i_rx_global_ctrl_opcode_max) begin
        o_class = MPFC_CLS_CTRL;
      end else if (et == i_rx_priority_ctrl_ethertype &&
                   op >= i_rx_priority_ctrl_opcode_min &&
                   op <= i_rx_priority_ctrl_opcode_max) begin
        o_class = MPFC_CLS_CTRL;
      end
    end
  end
endmodule : mpfc_classify

/* src/mpfc_tx_header.sv */
// builds the registered header of an outgoing pause frame
`timescale 1ns/1ns
`include "mpfc_defines.svh"
module mpfc_tx_header (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req_global,
  input wire logic i_req_priority,
  input wire logic [47:0] i_tx_global_pause_dest_addr,
  input wire logic [47:0] i_tx_global_pause_source_addr,
  input wire logic [15:0] i_tx_global_pause_ethertype,
  input wire logic [15:0] i_tx_global_pause_opcode,
  input wire logic [47:0] i_tx_priority_pause_dest_addr,
  input wire logic [47:0] i_tx_priority_pause_source_addr,
  input wire logic [15:0] i_tx_priority_pause_ethertype,
  input wire logic [15:0] i_tx_priority_pause_opcode,
  output logic [`MPFC_HDR_W-1:0] o_hdr,
  output logic o_hdr_valid
);
  import mpfc_pkg::*;
  typedef struct packed {
    logic [`MPFC_HDR_W-1:0] hdr;
    logic vld;
  } mpfc_txh_t;
  mpfc_txh_t st_reg;
  mpfc_txh_t st_next;
  // global request wins when both arrive together
  always_comb begin
    st_next = st_reg;
    st_next.vld = i_req_global | i_req_priority;
    if (i_req_global) begin
      st_next.hdr = {i_tx_global_pause_opcode, i_tx_global_pause_ethertype,
                     i_tx_global_pause_source_addr, i_tx_global_pause_dest_addr};
    end else if (i_req_priority) begin
      st_next.hdr = {i_tx_priority_pause_opcode, i_tx_priority_pause_ethertype,
                     i_tx_priority_pause_source_addr, i_tx_priority_pause_dest_addr};
    end
  end
  // state register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_hdr = st_reg.hdr;
  assign o_hdr_valid = st_reg.vld;
  property p_tx_hdr;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    i_req_global |=> (o_hdr_valid && o_hdr[`MPFC_ET_HI:`MPFC_ET_LO] == $past(i_tx_global_pause_ethertype));
  endproperty
  a_tx_hdr: assert property (p_tx_hdr) else $error("global pause header wrong");
  property p_tx_prio;
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_priority && !i_req_global) |=> o_hdr[`MPFC_OP_HI:`MPFC_OP_LO] == $past(i_tx_priority_pause_opcode);
  endproperty
  a_tx_prio: assert property (p_tx_prio) else $error("priority pause header wrong");
endmodule : mpfc_tx_header

/* src/mpfc_top.sv */
// receive fault gating, control filtering and pause handling
`timescale 1ns/1ns
`include "mpfc_defines.svh"
module mpfc_top #(
  parameter int ACK_W = `MPFC_ACK_W,
  parameter int DATA_W = 128
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_rx_local_fault_process_en,
  input wire logic i_rx_check_ack_en,
  input wire logic i_rx_forward_ctrl_en,
  input wire logic [47:0] i_rx_pause_unicast_dest_addr,
  input wire logic [47:0] i_rx_pause_source_addr,
  input wire logic [47:0] i_rx_pause_multicast_dest_addr,
  input wire logic [15:0] i_rx_global_ctrl_ethertype,
  input wire logic [15:0] i_rx_global_ctrl_opcode_min,
  input wire logic [15:0] i_rx_global_ctrl_opcode_max,
  input wire logic [15:0] i_rx_priority_ctrl_ethertype,
  input wire logic [15:0] i_rx_priority_ctrl_opcode_min,
  input wire logic [15:0] i_rx_priority_ctrl_opcode_max,
  input wire logic [15:0] i_rx_global_pause_ethertype,
  input wire logic [15:0] i_rx_global_pause_opcode,
  input wire logic [15:0] i_rx_priority_pause_ethertype,
  input wire logic [15:0] i_rx_priority_pause_opcode,
  input wire logic [ACK_W-1:0] i_rx_pause_ack,
  input wire logic i_local_fault_indication,
  input wire logic i_rx_start_block,
  input wire logic i_rx_ena,
  input wire logic i_rx_sop,
  input wire logic i_rx_eop,
  input wire logic i_rx_err,
  input wire logic [DATA_W-1:0] i_rx_data,
  input wire logic i_tx_pause_req_global,
  input wire logic i_tx_pause_req_priority,
  input wire logic [47:0] i_tx_global_pause_dest_addr,
  input wire logic [47:0] i_tx_global_pause_source_addr,
  input wire logic [15:0] i_tx_global_pause_ethertype,
  input wire logic [15:0] i_tx_global_pause_opcode,
  input wire logic [47:0] i_tx_priority_pause_dest_addr,
  input wire logic [47:0] i_tx_priority_pause_source_addr,
  input wire logic [15:0] i_tx_priority_pause_ethertype,
  input wire logic [15:0] i_tx_priority_pause_opcode,
  output logic o_rx_ena,
  output logic o_rx_sop,
  output logic o_rx_eop,
  output logic o_rx_err,
  output logic [DATA_W-1:0] o_rx_data,
  output logic o_rx_pause_pending,
  output logic o_rx_pause_is_priority,
  output logic o_rx_pause_from_peer,
  output logic o_rx_fault_blocked,
  output logic [`MPFC_HDR_W-1:0] o_tx_pause_hdr,
  output logic o_tx_pause_hdr_valid
);
  import mpfc_pkg::*;

  typedef struct packed {
    logic blocked;
    logic in_pkt;
    logic drop_pkt;
    logic ena;
    logic sop;
    logic eop;
    logic err;
    logic [DATA_W-1:0] data;
    logic pause_pend;
    logic pause_prio;
    logic pause_peer;
  } mpfc_state_t;

  mpfc_state_t st_reg;
  mpfc_state_t st_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic fault_now;
  logic [`MPFC_HDR_W-1:0] hdr_word;
  mpfc_class_t cls;
  logic is_pause;
  logic ack_seen;

  // reset is released through two flops so it leaves all logic on one edge
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  assign fault_now = i_rx_local_fault_process_en & i_local_fault_indication;

  // header assumed to sit in the first transfer of the packet
  assign hdr_word = i_rx_data[`MPFC_HDR_W-1:0];

  mpfc_classify u_classify (
    .i_hdr(hdr_word),
    .i_rx_pause_unicast_dest_addr(i_rx_pause_unicast_dest_addr),
    .i_rx_pause_multicast_dest_addr(i_rx_pause_multicast_dest_addr),
    .i_rx_global_ctrl_ethertype(i_rx_global_ctrl_ethertype),
    .i_rx_global_ctrl_opcode_min(i_rx_global_ctrl_opcode_min),
    .i_rx_global_ctrl_opcode_max(i_rx_global_ctrl_opcode_max),
    .i_rx_priority_ctrl_ethertype(i_rx_priority_ctrl_ethertype),
    .i_rx_priority_ctrl_opcode_min(i_rx_priority_ctrl_opcode_min),
    .i_rx_priority_ctrl_opcode_max(i_rx_priority_ctrl_opcode_max),
    .i_rx_global_pause_ethertype(i_rx_global_pause_ethertype),
    .i_rx_global_pause_opcode(i_rx_global_pause_opcode),
    .i_rx_priority_pause_ethertype(i_rx_priority_pause_ethertype),
    .i_rx_priority_pause_opcode(i_rx_priority_pause_opcode),
    .o_class(cls)
  );

  assign is_pause = (cls == MPFC_CLS_GPAUSE) || (cls == MPFC_CLS_PPAUSE);
  // acknowledge ignored when checking is off
  assign ack_seen = !i_rx_check_ack_en || (|i_rx_pause_ack);

  // receive datapath, fault gating and pause capture
  always_comb begin
    st_next = st_reg;
    st_next.ena = 1'b0;
    st_next.sop = 1'b0;
    st_next.eop = 1'b0;
    st_next.err = 1'b0;
    // pending until acknowledged; cleared first so a new pause wins
    if (st_reg.pause_pend && ack_seen) begin
      st_next.pause_pend = 1'b0;
    end
    if (fault_now) begin
      st_next.blocked = 1'b1;
    end else if (st_reg.blocked && i_rx_start_block) begin
      st_next.blocked = 1'b0;
    end
    if (fault_now || st_reg.blocked) begin
      if (st_reg.in_pkt && !st_reg.drop_pkt) begin
        st_next.ena = 1'b1;
        st_next.eop = 1'b1;
        st_next.err = 1'b1;
      end
      st_next.in_pkt = 1'b0;
      st_next.drop_pkt = 1'b0;
    end else if (i_rx_ena) begin
      if (i_rx_sop) begin
        st_next.in_pkt = !i_rx_eop;
        st_next.drop_pkt = (cls != MPFC_CLS_DATA) && !i_rx_forward_ctrl_en;
        // peer source compared to configured address
        if (is_pause) begin
          st_next.pause_pend = 1'b1;
          st_next.pause_prio = (cls == MPFC_CLS_PPAUSE);
          st_next.pause_peer =
            (hdr_word[`MPFC_SA_HI:`MPFC_SA_LO] == i_rx_pause_source_addr);
        end
      end else if (i_rx_eop) begin
        st_next.in_pkt = 1'b0;
      end
      if ((i_rx_sop || st_reg.in_pkt) && !(i_rx_sop ? st_next.drop_pkt : st_reg.drop_pkt)) begin
        st_next.ena = 1'b1;
        st_next.sop = i_rx_sop;
        st_next.eop = i_rx_eop;
        st_next.err = i_rx_err;
        st_next.data = i_rx_data;
      end
    end
  end

  // state register; synchroniser bits kept out of this process
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.blocked <= 1'b0;
      st_reg.in_pkt <= 1'b0;
      st_reg.drop_pkt <= 1'b0;
      st_reg.ena <= 1'b0;
      st_reg.sop <= 1'b0;
      st_reg.eop <= 1'b0;
      st_reg.err <= 1'b0;
      st_reg.data <= '0;
      st_reg.pause_pend <= 1'b0;
      st_reg.pause_prio <= 1'b0;
      st_reg.pause_peer <= 1'b0;
    end else begin
      st_reg.blocked <= st_next.blocked;
      st_reg.in_pkt <= st_next.in_pkt;
      st_reg.drop_pkt <= st_next.drop_pkt;
      st_reg.ena <= st_next.ena;
      st_reg.sop <= st_next.sop;
      st_reg.eop <= st_next.eop;
      st_reg.err <= st_next.err;
      st_reg.data <= st_next.data;
      st_reg.pause_pend <= st_next.pause_pend;
      st_reg.pause_prio <= st_next.pause_prio;
      st_reg.pause_peer <= st_next.pause_peer;
    end
  end

  mpfc_tx_header u_tx_header (
    .i_core_clk(i_core_clk),
    .i_rst_n(rst_n),
    .i_req_global(i_tx_pause_req_global),
    .i_req_priority(i_tx_pause_req_priority),
    .i_tx_global_pause_dest_addr(i_tx_global_pause_dest_addr),
    .i_tx_global_pause_source_addr(i_tx_global_pause_source_addr),
    .i_tx_global_pause_ethertype(i_tx_global_pause_ethertype),
    .i_tx_global_pause_opcode(i_tx_global_pause_opcode),
    .i_tx_priority_pause_dest_addr(i_tx_priority_pause_dest_addr),
    .i_tx_priority_pause_source_addr(i_tx_priority_pause_source_addr),
    .i_tx_priority_pause_ethertype(i_tx_priority_pause_ethertype),
    .i_tx_priority_pause_opcode(i_tx_priority_pause_opcode),
    .o_hdr(o_tx_pause_hdr),
    .o_hdr_valid(o_tx_pause_hdr_valid)
  );

  // outputs straight from flops
  assign o_rx_ena = st_reg.ena;
  assign o_rx_sop = st_reg.sop;
  assign o_rx_eop = st_reg.eop;
  assign o_rx_err = st_reg.err;
  assign o_rx_data = st_reg.data;
  assign o_rx_pause_pending = st_reg.pause_pend;
  assign o_rx_pause_is_priority = st_reg.pause_prio;
  assign o_rx_pause_from_peer = st_reg.pause_peer;
  assign o_rx_fault_blocked = st_reg.blocked;

  property p_no_rx_blocked;
    @(posedge i_core_clk) disable iff (!rst_n)
    (st_reg.blocked && $past(st_reg.blocked) && $past(st_reg.blocked, 2)) |-> !o_rx_sop;
  endproperty
  a_no_rx_blocked: assert property (p_no_rx_blocked) else $error("packet while blocked");
  property p_fault_blocks;
    @(posedge i_core_clk) disable iff (!rst_n)
    (i_rx_local_fault_process_en && i_local_fault_indication) |=> o_rx_fault_blocked;
  endproperty
  a_fault_blocks: assert property (p_fault_blocks) else $error("fault not honoured");
  property p_fault_ignored;
    @(posedge i_core_clk) disable iff (!rst_n)
    (!i_rx_local_fault_process_en && !o_rx_fault_blocked) |=> !o_rx_fault_blocked;
  endproperty
  a_fault_ignored: assert property (p_fault_ignored) else $error("fault acted on while off");
  sequence s_cut;
    st_reg.in_pkt && !st_reg.drop_pkt && fault_now;
  endsequence
  property p_cut_err;
    @(posedge i_core_clk) disable iff (!rst_n)
    s_cut |=> (o_rx_ena && o_rx_eop && o_rx_err);
  endproperty
  a_cut_err: assert property (p_cut_err) else $error("cut packet not flagged");
  property p_resume;
    @(posedge i_core_clk) disable iff (!rst_n)
    ($fell(o_rx_fault_blocked)) |-> $past(i_rx_start_block);
  endproperty
  a_resume: assert property (p_resume) else $error("resumed without start block");
  property p_err_eop;
    @(posedge i_core_clk) disable iff (!rst_n)
    (o_rx_err && !$past(i_rx_err)) |-> (o_rx_eop && o_rx_ena);
  endproperty
  a_err_eop: assert property (p_err_eop) else $error("error off last transfer");
  property p_ctrl_drop;
    @(posedge i_core_clk) disable iff (!rst_n)
    (!fault_now && !st_reg.blocked && i_rx_ena && i_rx_sop && cls != MPFC_CLS_DATA &&
     !i_rx_forward_ctrl_en) |=> !o_rx_ena;
  endproperty
  a_ctrl_drop: assert property (p_ctrl_drop) else $error("control frame forwarded");
  property p_ack_off;
    @(posedge i_core_clk) disable iff (!rst_n)
    (o_rx_pause_pending && !i_rx_check_ack_en && !(i_rx_ena && i_rx_sop)) |=> !o_rx_pause_pending;
  endproperty
  a_ack_off: assert property (p_ack_off) else $error("pause held without check");
endmodule : mpfc_top

/* tb/mpfc_user_model.sv */
// user logic model: acknowledges a received pause after a chosen delay
`timescale 1ns/1ns
module mpfc_user_model (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_pause_pending,
  input wire logic [3:0] i_delay,
  output logic [8:0] o_rx_pause_ack
);
  logic [3:0] cnt_reg;
  // acknowledge held until pending drops; top bit only, to see the full width is used
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 4'h0;
      o_rx_pause_ack <= 9'h000;
    end else if (!i_pause_pending) begin
      cnt_reg <= 4'h0;
      o_rx_pause_ack <= 9'h000;
    end else if (cnt_reg >= i_delay) begin
      o_rx_pause_ack <= 9'h100;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : mpfc_user_model

/* tb/mpfc_top_bench.sv */
// self-checking bench for the pause and fault control block
`timescale 1ns/1ns
`include "mpfc_defines.svh"
module mpfc_top_bench;
  logic clk, rstn, fault_en, ack_en, fwd_en, lf, sb, ena, sop, eop, err, rg, rp;
  logic [47:0] ucast, rsa, mcast, tgda, tgsa, tpda, tpsa;
  logic [15:0] gct_et, gct_min, gct_max, pct_et, pct_min, pct_max, gp_et, gp_op, pp_et, pp_op;
  logic [15:0] tget, tgop, tpet, tpop;
  logic [127:0] dat, q_dat, thdr;
  logic q_ena, q_sop, q_eop, q_err, pend, pprio, ppeer, blk, tval;
  logic [8:0] ack;
  logic [3:0] dly;
  int n_mismatch, tests_run;
  int cyc = 0;
  mpfc_top dut (.i_core_clk(clk), .i_resetn(rstn), .i_rx_local_fault_process_en(fault_en),
    .i_rx_check_ack_en(ack_en), .i_rx_forward_ctrl_en(fwd_en),
    .i_rx_pause_unicast_dest_addr(ucast), .i_rx_pause_source_addr(rsa),
    .i_rx_pause_multicast_dest_addr(mcast), .i_rx_global_ctrl_ethertype(gct_et),
    .i_rx_global_ctrl_opcode_min(gct_min), .i_rx_global_ctrl_opcode_max(gct_max),
    .i_rx_priority_ctrl_ethertype(pct_et), .i_rx_priority_ctrl_opcode_min(pct_min),
    .i_rx_priority_ctrl_opcode_max(pct_max), .i_rx_global_pause_ethertype(gp_et),
    .i_rx_global_pause_opcode(gp_op), .i_rx_priority_pause_ethertype(pp_et),
    .i_rx_priority_pause_opcode(pp_op), .i_rx_pause_ack(ack), .i_local_fault_indication(lf),
    .i_rx_start_block(sb), .i_rx_ena(ena), .i_rx_sop(sop), .i_rx_eop(eop), .i_rx_err(err),
    .i_rx_data(dat), .i_tx_pause_req_global(rg), .i_tx_pause_req_priority(rp),
    .i_tx_global_pause_dest_addr(tgda), .i_tx_global_pause_source_addr(tgsa),
    .i_tx_global_pause_ethertype(tget), .i_tx_global_pause_opcode(tgop),
    .i_tx_priority_pause_dest_addr(tpda), .i_tx_priority_pause_source_addr(tpsa),
    .i_tx_priority_pause_ethertype(tpet), .i_tx_priority_pause_opcode(tpop),
    .o_rx_ena(q_ena), .o_rx_sop(q_sop), .o_rx_eop(q_eop), .o_rx_err(q_err), .o_rx_data(q_dat),
    .o_rx_pause_pending(pend), .o_rx_pause_is_priority(pprio), .o_rx_pause_from_peer(ppeer),
    .o_rx_fault_blocked(blk), .o_tx_pause_hdr(thdr), .o_tx_pause_hdr_valid(tval));
  mpfc_user_model user (.i_core_clk(clk), .i_resetn(rstn), .i_pause_pending(pend),
    .i_delay(dly), .o_rx_pause_ack(ack));
  // 10 MHz core clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard: the whole run needs well under 1000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  task automatic chk_word(input string nm, input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  function automatic logic [127:0] hdr(input logic [47:0] da, input logic [47:0] sa,
                                       input logic [15:0] et, input logic [15:0] op);
    return {op, et, sa, da};
  endfunction : hdr
  // one transfer on the input bus; outputs are looked at one cycle later
  task automatic xfer(input logic s, input logic e, input logic [127:0] d);
    @(posedge clk);
    ena <= 1'b1;
    sop <= s;
    eop <= e;
    dat <= d;
    @(posedge clk);
    ena <= 1'b0;
    sop <= 1'b0;
    eop <= 1'b0;
    #1;
  endtask : xfer
  // single-transfer packet, passed through or swallowed as expected
  task automatic pkt(input logic [127:0] d, input logic pass);
    xfer(1'b1, 1'b1, d);
    chk_bit("rx_ena", pass, q_ena);
    if (pass) begin
      chk_bit("rx_sop", 1'b1, q_sop);
      chk_word("rx_data", d, q_dat);
    end
  endtask : pkt
  // configuration only changes while the datapath is held in reset
  task automatic do_reset(input logic f, input logic a, input logic w, input logic [15:0] g);
    @(posedge clk);
    rstn <= 1'b0;
    fault_en <= f;
    ack_en <= a;
    fwd_en <= w;
    gct_et <= g;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // pause frame: pending raised, kind and peer flags reported, then cleared within a bound
  task automatic pause(input logic [127:0] d, input logic pri, input logic peer, input int keep);
    int i;
    pkt(d, 1'b0);
    chk_bit("pause_pending", 1'b1, pend);
    chk_bit("pause_is_priority", pri, pprio);
    chk_bit("pause_from_peer", peer, ppeer);
    repeat (keep) @(posedge clk);
    #1;
    if (keep > 0) chk_bit("pause_pending_held", 1'b1, pend);
    // look after each edge has settled, never in the edge's own time step
    for (i = 0; i < 12 && pend !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk_bit("pause_pending_cleared", 1'b0, pend);
  endtask : pause
  // one pause header request on the transmit side
  task automatic txreq(input logic pri, input logic [127:0] e);
    @(posedge clk);
    rg <= !pri;
    rp <= pri;
    @(posedge clk);
    rg <= 1'b0;
    rp <= 1'b0;
    #1;
    chk_bit("tx_hdr_valid", 1'b1, tval);
    chk_word("tx_hdr", e, thdr);
    @(posedge clk);
    #1;
    chk_bit("tx_hdr_valid_pulse", 1'b0, tval);
  endtask : txreq
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    {rstn, fault_en, fwd_en, lf, sb, ena, sop, eop, err, rg, rp} = '0;
    ack_en = 1'b1;
    dat = '0;
    dly = 4'h4;
    n_mismatch = 0;
    tests_run = 0;
    ucast = 48'h02AABBCCDDEE;
    rsa = `MPFC_ADDR_ZERO;
    mcast = `MPFC_PAUSE_GROUP_ADDR;
    {gct_et, pct_et, gp_et, pp_et} = {4{`MPFC_CTRL_ETHERTYPE}};
    {gct_min, gct_max} = {`MPFC_GLOBAL_OPCODE_MIN, `MPFC_GLOBAL_OPCODE_MAX};
    {pct_min, pct_max} = {`MPFC_PRIO_OPCODE_MIN, `MPFC_PRIO_OPCODE_MAX};
    {gp_op, pp_op} = {`MPFC_GLOBAL_PAUSE_OPCODE, `MPFC_PRIO_PAUSE_OPCODE};
    {tgda, tpda} = {2{`MPFC_PAUSE_GROUP_ADDR}};
    tgsa = 48'h021122334455;
    tpsa = 48'h026677889900;
    {tget, tpet} = {2{`MPFC_CTRL_ETHERTYPE}};
    {tgop, tpop} = {`MPFC_GLOBAL_PAUSE_OPCODE, `MPFC_PRIO_PAUSE_OPCODE};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    // phase one: defaults, acknowledge checked, forwarding off, faults ignored
    pkt(hdr(48'h02000000BEEF, 48'h1, 16'h0800, 16'h4500), 1'b1);
    pkt(hdr(48'h02000000BEEF, 48'h0, 16'h8808, 16'h0001), 1'b1);
    chk_bit("pause_pending_no_da", 1'b0, pend);
    pause(hdr(mcast, rsa, 16'h8808, 16'h0001), 1'b0, 1'b1, 3);
    dly <= 4'h0;
    pause(hdr(ucast, 48'h0A0B0C0D0E0F, 16'h8808, 16'h0101), 1'b1, 1'b0, 0);
    pkt(hdr(mcast, 48'h5, 16'h8808, 16'hFFFF), 1'b0);
    pkt(hdr(mcast, 48'h5, 16'h8808, 16'h0500), 1'b0);
    @(posedge clk);
    lf <= 1'b1;
    pkt(hdr(48'h0200000000A1, 48'h1, 16'h0800, 16'h0), 1'b1);
    chk_bit("fault_blocked_off", 1'b0, blk);
    @(posedge clk);
    lf <= 1'b0;
    txreq(1'b0, hdr(`MPFC_PAUSE_GROUP_ADDR, tgsa, 16'h8808, 16'h0001));
    txreq(1'b1, hdr(`MPFC_PAUSE_GROUP_ADDR, tpsa, 16'h8808, 16'h0101));
    // phase two: fault processing on, no acknowledge, global control class moved away
    dly <= 4'hF;
    do_reset(1'b1, 1'b0, 1'b0, 16'h9999);
    pkt(hdr(mcast, 48'h5, 16'h8808, 16'h0ABC), 1'b0);
    pkt(hdr(mcast, 48'h5, 16'h8808, 16'h1000), 1'b1);
    pkt(hdr(mcast, 48'h5, 16'h9999, 16'h1234), 1'b0);
    pause(hdr(mcast, rsa, 16'h8808, 16'h0001), 1'b0, 1'b1, 0);
    xfer(1'b1, 1'b0, hdr(48'h0200000000A2, 48'h1, 16'h0800, 16'h0));
    chk_bit("rx_ena_before_fault", 1'b1, q_ena);
    @(posedge clk);
    lf <= 1'b1;
    @(posedge clk);
    #1;
    chk_bit("cut_ena", 1'b1, q_ena);
    chk_bit("cut_eop", 1'b1, q_eop);
    chk_bit("cut_err", 1'b1, q_err);
    chk_bit("fault_blocked", 1'b1, blk);
    pkt(hdr(48'h0200000000A3, 48'h1, 16'h0800, 16'h0), 1'b0);
    @(posedge clk);
    lf <= 1'b0;
    pkt(hdr(48'h0200000000A4, 48'h1, 16'h0800, 16'h0), 1'b0);
    chk_bit("blocked_until_start", 1'b1, blk);
    @(posedge clk);
    sb <= 1'b1;
    @(posedge clk);
    sb <= 1'b0;
    #1;
    chk_bit("blocked_after_start", 1'b0, blk);
    pkt(hdr(48'h0200000000A5, 48'h1, 16'h0800, 16'h0), 1'b1);
    // phase three: control frames forwarded to the user side
    do_reset(1'b0, 1'b1, 1'b1, `MPFC_CTRL_ETHERTYPE);
    pkt(hdr(mcast, 48'h5, 16'h8808, 16'h0500), 1'b1);
    print_verdict();
  end
endmodule : mpfc_top_bench
